// file: common/hsx_pkg.sv
package hsx_pkg;
    // instruction encodings
    localparam logic [11:0] HSX_OPC_HALT = 12'h003;
    localparam logic [5:0] HSX_OPC_SUB_HI = 6'h02; // 0000 10
    localparam logic [5:0] HSX_OPC_SWAP_HI = 6'h0E; // 0011 10
    localparam int HSX_DEST_BIT = 5;
    localparam int HSX_FADDR_W = 5;
    // status bit positions
    localparam int HSX_ST_C = 0;
    localparam int HSX_ST_DC = 1;
    localparam int HSX_ST_Z = 2;
    localparam int HSX_ST_PD = 3;
    localparam int HSX_ST_TO = 4;
    localparam logic [7:0] HSX_STATUS_RST = 8'h18;
    localparam logic [7:0] HSX_WDT_CLR = 8'h00;
    // register bus offsets
    localparam logic [11:0] HSX_A_INSTR = 12'h000;
    localparam logic [11:0] HSX_A_WREG = 12'h004;
    localparam logic [11:0] HSX_A_STATUS = 12'h008;
    localparam logic [11:0] HSX_A_CTRL = 12'h00C;
    localparam logic [11:0] HSX_A_WDT = 12'h010;
    localparam logic [11:0] HSX_A_FILE = 12'h080; // 32 words
    localparam int HSX_FILE_N = 32;

    typedef struct packed {
        logic [7:0] res;
        logic [4:0] faddr;
        logic to_dest_file;
        logic wr_file;
        logic wr_w;
        logic flags_upd;
        logic halt;
    } hsx_exec_t;
endpackage

// file: rtl/hsx_alu.sv
`timescale 1ns/1ps
`default_nettype none
module hsx_alu import hsx_pkg::*; (
    input wire logic [11:0] instr,
    input wire logic [7:0] fval,
    input wire logic [7:0] wval,
    output logic [7:0] res,
    output logic c_out,
    output logic dc_out,
    output logic z_out,
    output logic is_sub,
    output logic is_swap,
    output logic is_halt
);
    logic [8:0] diff;
    logic [4:0] ndiff;
    // decode and compute both results
    always_comb begin
        is_halt = (instr == HSX_OPC_HALT);
        is_sub = (instr[11:6] == HSX_OPC_SUB_HI);
        is_swap = (instr[11:6] == HSX_OPC_SWAP_HI);
        diff = {1'b0, fval} + {1'b0, ~wval} + 9'h001;
        ndiff = {1'b0, fval[3:0]} + {1'b0, ~wval[3:0]} + 5'h01;
        c_out = diff[8];
        dc_out = ndiff[4];
        res = is_swap ? {fval[3:0], fval[7:4]} : diff[7:0];
        z_out = (diff[7:0] == 8'h00);
    end
endmodule
`default_nettype wire

// file: rtl/hsx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module hsx_exec import hsx_pkg::*; #(
    parameter int WDT_W = 8,
    parameter int PRE_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wake,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic osc_run,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic [WDT_W-1:0] watchdog_counter
);
    // wake synchroniser state
    logic wake_s1_reg;
    logic wake_s1_next;
    logic wake_s2_reg;
    logic wake_s2_next;
    // core state
    logic [11:0] instr_reg;
    logic [11:0] instr_next;
    logic go_reg;
    logic go_next;
    logic [7:0] w_reg;
    logic [7:0] w_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic halted_reg;
    logic halted_next;
    logic osc_run_reg;
    logic osc_run_next;
    // watchdog state
    logic wdt_en_reg;
    logic wdt_en_next;
    logic [WDT_W-1:0] wdt_reg;
    logic [WDT_W-1:0] wdt_next;
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    // bus answer state
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    // datapath and bus decode
    logic [7:0] fval;
    logic [7:0] fbus;
    logic [7:0] alu_res;
    logic c_o;
    logic dc_o;
    logic z_o;
    logic is_sub;
    logic is_swap;
    logic is_halt;
    logic bus_fwe;
    hsx_exec_t ex;
    logic access;
    logic wr;
    logic rd;
    logic file_hit;

    // wake pin synchroniser: two flops before any logic reads the pin
    always_comb begin
        wake_s1_next = wake;
        wake_s2_next = wake_s1_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= wake_s1_next;
            wake_s2_reg <= wake_s2_next;
        end
    end

    hsx_alu u_alu (
        .instr(instr_reg),
        .fval(fval),
        .wval(w_reg),
        .res(alu_res),
        .c_out(c_o),
        .dc_out(dc_o),
        .z_out(z_o),
        .is_sub(is_sub),
        .is_swap(is_swap),
        .is_halt(is_halt)
    );

    hsx_regfile #(.N(HSX_FILE_N)) u_rf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .raddr_a(instr_reg[HSX_FADDR_W-1:0]),
        .rdata_a(fval),
        .raddr_b(paddr[6:2]),
        .rdata_b(fbus),
        .we(ex.wr_file | bus_fwe),
        .waddr(ex.wr_file ? ex.faddr : paddr[6:2]),
        .wdata(ex.wr_file ? ex.res : pwdata[7:0])
    );

    assign access = psel && penable && !pready_reg;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign file_hit = (paddr[11:7] == HSX_A_FILE[11:7]);
    // bus file write yields to an executing instruction
    assign bus_fwe = wr && file_hit && !ex.wr_file;

    // execute stage: one instruction in one cycle
    always_comb begin
        ex = '0;
        ex.faddr = instr_reg[HSX_FADDR_W-1:0];
        ex.to_dest_file = instr_reg[HSX_DEST_BIT];
        ex.res = alu_res;
        if (go_reg && !halted_reg) begin
            ex.halt = is_halt;
            ex.flags_upd = is_sub;
            ex.wr_file = (is_sub || is_swap) && ex.to_dest_file;
            ex.wr_w = (is_sub || is_swap) && !ex.to_dest_file;
        end
    end

    // instruction latch: a bus write runs the opcode once
    always_comb begin
        instr_next = instr_reg;
        go_next = 1'b0;
        if (wr && !halted_reg && paddr == HSX_A_INSTR) begin
            instr_next = pwdata[11:0];
            go_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            instr_reg <= 12'h000;
            go_reg <= 1'b0;
        end else begin
            instr_reg <= instr_next;
            go_reg <= go_next;
        end
    end

    // working register: the instruction beats a same-cycle bus write
    always_comb begin
        w_next = w_reg;
        if (ex.wr_w) begin
            w_next = ex.res;
        end else if (wr && paddr == HSX_A_WREG) begin
            w_next = pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            w_reg <= 8'h00;
        end else begin
            w_reg <= w_next;
        end
    end

    // status: arithmetic flags, halt flags, bus write of the low bits
    always_comb begin
        status_next = status_reg;
        if (ex.flags_upd) begin
            status_next[HSX_ST_C] = c_o;
            status_next[HSX_ST_DC] = dc_o;
            status_next[HSX_ST_Z] = z_o;
        end else if (ex.halt) begin
            status_next[HSX_ST_TO] = 1'b1;
            status_next[HSX_ST_PD] = 1'b0;
        end else if (wr && paddr == HSX_A_STATUS) begin
            status_next[HSX_ST_Z:HSX_ST_C] = pwdata[HSX_ST_Z:HSX_ST_C];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_reg <= HSX_STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // halt state and the registered oscillator run output
    always_comb begin
        halted_next = halted_reg;
        if (ex.halt) begin
            halted_next = 1'b1;
        end else if (halted_reg && wake_s2_reg) begin
            halted_next = 1'b0;
        end
        osc_run_next = !halted_next;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            halted_reg <= 1'b0;
            osc_run_reg <= 1'b1;
        end else begin
            halted_reg <= halted_next;
            osc_run_reg <= osc_run_next;
        end
    end

    // watchdog enable, prescaler and counter; frozen while halted
    always_comb begin
        wdt_en_next = wdt_en_reg;
        pre_next = pre_reg + PRE_W'(1);
        wdt_next = wdt_reg;
        if (wdt_en_reg && &pre_reg) begin
            wdt_next = wdt_reg + WDT_W'(1);
        end
        if (ex.halt) begin
            wdt_next = WDT_W'(HSX_WDT_CLR);
            pre_next = '0;
        end else if (halted_reg) begin
            pre_next = pre_reg; // oscillator stopped, nothing counts
            wdt_next = wdt_reg;
        end
        if (wr && paddr == HSX_A_CTRL) begin
            wdt_en_next = pwdata[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wdt_en_reg <= 1'b0;
            wdt_reg <= '0;
            pre_reg <= '0;
        end else begin
            wdt_en_reg <= wdt_en_next;
            wdt_reg <= wdt_next;
            pre_reg <= pre_next;
        end
    end

    // apb slave: answers one cycle into the access phase
    always_comb begin
        pready_next = access;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (rd) begin
            if (file_hit) begin
                prdata_next = {24'h000000, fbus};
            end else begin
                unique case (paddr)
                    HSX_A_INSTR: prdata_next = {20'h00000, instr_reg};
                    HSX_A_WREG: prdata_next = {24'h000000, w_reg};
                    HSX_A_STATUS: prdata_next = {24'h000000, status_reg};
                    HSX_A_CTRL: prdata_next = {30'h0, halted_reg, wdt_en_reg};
                    HSX_A_WDT: prdata_next = 32'(wdt_reg);
                    default: pslverr_next = 1'b1;
                endcase
            end
        end else if (wr && !file_hit && paddr != HSX_A_INSTR &&
                     paddr != HSX_A_WREG && paddr != HSX_A_STATUS &&
                     paddr != HSX_A_CTRL) begin
            pslverr_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign osc_run = osc_run_reg;
    assign timeout_flag_n = status_reg[HSX_ST_TO];
    assign powerdown_flag_n = status_reg[HSX_ST_PD];
    assign watchdog_counter = wdt_reg;
endmodule
`default_nettype wire

// file: rtl/hsx_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module hsx_regfile import hsx_pkg::*; #(
    parameter int N = HSX_FILE_N
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [4:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [4:0] raddr_b,
    output logic [7:0] rdata_b,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] mem_reg [N];
    logic [7:0] mem_next [N];
    // write port
    always_comb begin
        for (int i = 0; i < N; i++) begin
            mem_next[i] = (we && waddr == 5'(i)) ? wdata : mem_reg[i];
        end
    end
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < N; i++) begin
            mem_reg[i] <= sys_rst ? 8'h00 : mem_next[i];
        end
    end
    assign rdata_a = mem_reg[raddr_a];
    assign rdata_b = mem_reg[raddr_b];
endmodule
`default_nettype wire

// file: verification/hsx_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module hsx_exec_props import hsx_pkg::*; #(
    parameter int WDT_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic wake,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_run,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic [WDT_W-1:0] watchdog_counter
);
    logic halt_wr;
    // halt opcode accepted on the bus while running
    assign halt_wr = psel && penable && pready && pwrite && osc_run &&
        paddr == HSX_A_INSTR && pwdata[11:0] == HSX_OPC_HALT;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_halt_to; halt_wr |=> timeout_flag_n; endproperty
    a_halt_to: assert property (p_halt_to)
        else $error("timeout flag not set by halt");
    property p_halt_pd; halt_wr |=> !powerdown_flag_n; endproperty
    a_halt_pd: assert property (p_halt_pd)
        else $error("powerdown flag not cleared by halt");
    property p_halt_wdt; halt_wr |=> watchdog_counter == '0; endproperty
    a_halt_wdt: assert property (p_halt_wdt)
        else $error("watchdog not cleared by halt");
    property p_halt_osc; halt_wr |=> !osc_run; endproperty
    a_halt_osc: assert property (p_halt_osc)
        else $error("oscillator still running after halt");
    property p_idle_wdt; !osc_run |-> watchdog_counter == '0; endproperty
    a_idle_wdt: assert property (p_idle_wdt)
        else $error("watchdog moved while halted");
    property p_pd_cause; $fell(powerdown_flag_n) |-> $past(halt_wr); endproperty
    a_pd_cause: assert property (p_pd_cause)
        else $error("powerdown flag fell without halt");
    property p_one_cyc; psel && penable && !pready |=> pready; endproperty
    a_one_cyc: assert property (p_one_cyc)
        else $error("bus answer late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("ready longer than one cycle");
endmodule
bind hsx_exec hsx_exec_props #(.WDT_W(WDT_W)) i_props (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wake(wake),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc_run(osc_run),
    .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n),
    .watchdog_counter(watchdog_counter)
);
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import hsx_pkg::*; ;
    logic clk_sys = 0, sys_rst = 1, wake = 0;
    logic [11:0] paddr = '0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, osc_run, timeout_flag_n, powerdown_flag_n, erv;
    logic [7:0] watchdog_counter;
    int fail_count = 0, n_compared = 0, cyc = 0;
    hsx_exec i_hsx_exec (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wake(wake),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .osc_run(osc_run),
        .timeout_flag_n(timeout_flag_n),
        .powerdown_flag_n(powerdown_flag_n),
        .watchdog_counter(watchdog_counter)
    );
    // clock and hang guard
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    task results;
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rdv = prdata;
        erv = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [11:0] fa(input logic [4:0] f);
        return HSX_A_FILE + {5'h0, f, 2'h0};
    endfunction
    task automatic t_sub;
        logic [7:0] fv[4] = '{8'h03, 8'h02, 8'h01, 8'h10};
        logic [7:0] wv[4] = '{8'h02, 8'h02, 8'h02, 8'h01};
        logic [7:0] r;
        for (int i = 0; i < 4; i++) begin
            r = fv[i] - wv[i];
            apb(1, fa(5'(i + 1)), {24'h0, fv[i]});
            apb(1, HSX_A_WREG, {24'h0, wv[i]});
            apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_SUB_HI, i[0], 5'(i + 1)});
            apb(0, i[0] ? fa(5'(i + 1)) : HSX_A_WREG, '0);
            chk(rdv, {24'h0, r});
            apb(0, HSX_A_STATUS, '0);
            chk(rdv[2:0], {r == 8'h0, fv[i][3:0] >= wv[i][3:0],
                fv[i] >= wv[i]});
        end
    endtask
    task t_swap;
        apb(1, fa(5'h07), 32'hA5);
        apb(1, HSX_A_STATUS, 32'h07);
        apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_SWAP_HI, 1'h0, 5'h07});
        apb(0, HSX_A_WREG, '0);
        chk(rdv, 32'h5A);
        apb(0, fa(5'h07), '0);
        chk(rdv, 32'hA5);
        apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_SWAP_HI, 1'h1, 5'h07});
        apb(0, fa(5'h07), '0);
        chk(rdv, 32'h5A);
        apb(0, HSX_A_STATUS, '0);
        chk(rdv[2:0], 3'h7);
        apb(0, 12'h020, '0);
        chk(erv, 1'h1);
    endtask
    task t_halt;
        apb(1, HSX_A_CTRL, 32'h1);
        repeat (700) @(posedge clk_sys);
        chk(watchdog_counter != 8'h0, 1'h1);
        apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_HALT});
        #1;
        chk(osc_run, 1'h0);
        chk(timeout_flag_n, 1'h1);
        chk(powerdown_flag_n, 1'h0);
        chk(watchdog_counter, 8'h0);
        apb(1, HSX_A_WREG, 32'h33);
        apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_SWAP_HI, 1'h0, 5'h07});
        apb(0, HSX_A_WREG, '0);
        chk(rdv, 32'h33);
    endtask
    task t_wake;
        @(posedge clk_sys);
        wake <= 1;
        repeat (3) @(posedge clk_sys);
        wake <= 0;
        for (int i = 0; i < 10 && osc_run !== 1'h1; i++) @(posedge clk_sys);
        chk(osc_run, 1'h1);
        apb(1, HSX_A_INSTR, {20'h0, HSX_OPC_SWAP_HI, 1'h0, 5'h07});
        apb(0, HSX_A_WREG, '0);
        chk(rdv, 32'hA5);
        apb(0, HSX_A_STATUS, '0);
        chk(rdv[4:3], 2'h2);
        // prescaler restarted from zero at halt: no count for 256 cycles
        repeat (230) @(posedge clk_sys);
        chk(watchdog_counter, 8'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 0;
        t_sub();
        t_swap();
        t_halt();
        t_wake();
        results();
    end
endmodule
`default_nettype wire
